// ===== include/ctc_consts.vh
`ifndef CTC_CONSTS_VH
`define CTC_CONSTS_VH

// Register addresses
`define CTC_ADDR_TERM_TIMER 8'h05
`define CTC_ADDR_IR_THERM 8'h06
`define CTC_ADDR_MISC 8'h07
`define CTC_ADDR_FAULT 8'h09

// Reset images
`define CTC_RST_TERM_TIMER 8'h9A
`define CTC_RST_IR_THERM 8'h03
`define CTC_RST_MISC 8'h4B

// Termination/timer control fields
`define CTC_B_EN_TERM 7
`define CTC_B_TERM_STAT 6
`define CTC_B_WDT_HI 5
`define CTC_B_WDT_LO 4
`define CTC_B_EN_TIMER 3
`define CTC_B_TMR_HI 2
`define CTC_B_TMR_LO 1
`define CTC_B_COLD_SCALE 0

// IR compensation / thermal fields
`define CTC_B_IRR_HI 7
`define CTC_B_IRR_LO 5
`define CTC_B_IRV_HI 4
`define CTC_B_IRV_LO 2
`define CTC_B_TEMP_HI 1
`define CTC_B_TEMP_LO 0

// Misc operation fields
`define CTC_B_FORCE_DET 7
`define CTC_B_HALFSPEED 6
`define CTC_B_BATT_OFF 5
`define CTC_B_WARM_VRED 4
`define CTC_B_MASK_CHG 1
`define CTC_B_MASK_BAT 0

// Fault register fields
`define CTC_B_WDT_FAULT 7
`define CTC_B_CHG_FAULT_HI 5
`define CTC_B_CHG_FAULT_LO 4
`define CTC_B_BATTERY_OVERVOLTAGE_FLAG 3
`define CTC_CHG_FAULT_TIMER 2'h3

// Timing
`define CTC_CLK_HZ 200000000
`define CTC_TICK_S 1
`define CTC_TICK_CYCLES (`CTC_CLK_HZ * `CTC_TICK_S)
`define CTC_WDT_40S 40
`define CTC_WDT_80S 80
`define CTC_WDT_160S 160
`define CTC_SAFE_5H 5
`define CTC_SAFE_8H 8
`define CTC_SAFE_12H 12
`define CTC_SAFE_20H 20
`define CTC_SEC_PER_HOUR 3600

// Analog setting steps
`define CTC_IRR_STEP_MOHM 10
`define CTC_IRV_STEP_MV 16
`define CTC_TEMP_BASE_C 60
`define CTC_TEMP_STEP_C 20
`define CTC_COLD_PCT_LO 50
`define CTC_COLD_PCT_HI 20

// Serial address, value is arbitrary
`define CTC_DEV_ADDR 7'h2A

`endif

// ===== hw/ctc_serial_slave.v
`timescale 1ns/1ps
`include "ctc_consts.vh"

module ctc_serial_slave #(
  parameter [6:0] DEV_ADDR = `CTC_DEV_ADDR
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire [7:0] i_rd_data,
  output reg o_sda_oe,
  output reg [7:0] o_reg_ptr,
  output reg o_wr_en,
  output reg [7:0] o_wr_data,
  output reg o_rd_take,
  output reg o_access
);

  localparam [9:0] ST_IDLE = 10'h001;
  localparam [9:0] ST_ADDR = 10'h002;
  localparam [9:0] ST_AACK = 10'h004;
  localparam [9:0] ST_PTR = 10'h008;
  localparam [9:0] ST_PACK = 10'h010;
  localparam [9:0] ST_WDAT = 10'h020;
  localparam [9:0] ST_WACK = 10'h040;
  localparam [9:0] ST_RDAT = 10'h080;
  localparam [9:0] ST_RACK = 10'h100;
  localparam [9:0] ST_RNEXT = 10'h200;

  reg [9:0] state_q;
  reg scl_q;
  reg sda_q;
  reg [2:0] cnt_q;
  reg [7:0] sh_q;
  reg rw_q;
  reg ack_q;

  wire rise = i_scl & ~scl_q;
  wire fall = ~i_scl & scl_q;
  wire start = scl_q & i_scl & sda_q & ~i_sda;
  wire stop = scl_q & i_scl & ~sda_q & i_sda;
  wire [7:0] byte_in = {sh_q[6:0], i_sda};

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      o_sda_oe <= 1'b0;
      o_reg_ptr <= 8'h00;
      o_wr_en <= 1'b0;
      o_wr_data <= 8'h00;
      o_rd_take <= 1'b0;
      o_access <= 1'b0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      o_wr_en <= 1'b0;
      o_rd_take <= 1'b0;
      o_access <= 1'b0;
      if (start) begin
        state_q <= ST_ADDR;
        cnt_q <= 3'h0;
        ack_q <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop) begin
        state_q <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_PTR, ST_WDAT: begin
            if (rise) begin
              sh_q <= byte_in;
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                if (state_q == ST_ADDR) begin
                  if (byte_in[7:1] == DEV_ADDR) begin
                    rw_q <= byte_in[0];
                    o_access <= 1'b1;
                    state_q <= ST_AACK;
                  end else begin
                    state_q <= ST_IDLE;
                  end
                end else if (state_q == ST_PTR) begin
                  o_reg_ptr <= byte_in;
                  state_q <= ST_PACK;
                end else begin
                  o_wr_en <= 1'b1;
                  o_wr_data <= byte_in;
                  state_q <= ST_WACK;
                end
              end
            end
          end
          ST_AACK, ST_PACK, ST_WACK: begin
            if (fall) begin
              if (!ack_q) begin
                o_sda_oe <= 1'b1;
                ack_q <= 1'b1;
              end else begin
                ack_q <= 1'b0;
                cnt_q <= 3'h0;
                if (state_q == ST_AACK && rw_q) begin
                  sh_q <= {i_rd_data[6:0], 1'b0};
                  o_sda_oe <= ~i_rd_data[7];
                  o_rd_take <= 1'b1;
                  state_q <= ST_RDAT;
                end else begin
                  o_sda_oe <= 1'b0;
                  state_q <= (state_q == ST_AACK) ? ST_PTR : ST_WDAT;
                  if (state_q == ST_WACK) begin
                    o_reg_ptr <= o_reg_ptr + 8'h01;
                  end
                end
              end
            end
          end
          ST_RDAT: begin
            if (rise) begin
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                state_q <= ST_RACK;
              end
            end else if (fall) begin
              o_sda_oe <= ~sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            if (fall) begin
              o_sda_oe <= 1'b0;
            end else if (rise) begin
              if (i_sda) begin
                state_q <= ST_IDLE;
              end else begin
                o_reg_ptr <= o_reg_ptr + 8'h01;
                state_q <= ST_RNEXT;
              end
            end
          end
          ST_RNEXT: begin
            if (fall) begin
              sh_q <= {i_rd_data[6:0], 1'b0};
              o_sda_oe <= ~i_rd_data[7];
              o_rd_take <= 1'b1;
              cnt_q <= 3'h0;
              state_q <= ST_RDAT;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // ctc_serial_slave

// ===== hw/ctc_control_regs.v
// Operation
// - Bit 7 enables termination, resets to one
// - Bit 6 selects early done below 800 mA
// - Watchdog field: off, 40, 80, 160 s
// - Safety timer enable, 5/8/12/20 hour duration
// - Bit 0 scales cold current 50%/20%
// - IR resistance field, 10 milliohm steps
// - IR voltage clamp field, 16 mV steps
// - Die temperature threshold 60 to 120 C
// - Compensation register resets 03, fully read/write
// - Misc register resets 4B, all read/write
// - Watchdog expiry sets read-only fault bit 7
// - Halfspeed bit halves safety timer when limiting
// - Mask bits gate charge and overvoltage interrupts
`timescale 1ns/1ps
`include "ctc_consts.vh"

module ctc_control_regs #(
  parameter [31:0] TICK_CYCLES = `CTC_TICK_CYCLES,
  parameter [6:0] DEV_ADDR = `CTC_DEV_ADDR
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  input wire i_fast_charging,
  input wire i_term_current_reached,
  input wire i_current_below_800ma,
  input wire i_input_limit_active,
  input wire i_thermal_reg_active,
  input wire i_port_detect_done,
  input wire i_charge_fault_event,
  input wire i_bat_ov_event,
  output reg o_term_enable,
  output reg o_done_status,
  output reg [7:0] o_wdt_period_s,
  output reg o_watchdog_fault,
  output reg o_safety_timer_enable,
  output reg [4:0] o_fast_charge_time_limit_h,
  output reg o_safety_timer_expired,
  output reg [6:0] o_cold_charge_current_pct,
  output reg [6:0] o_ir_comp_resistance_mohm,
  output reg [6:0] o_ir_comp_voltage_limit_mv,
  output reg [6:0] o_die_temp_threshold_c,
  output reg o_force_port_detect,
  output reg o_timer_halfspeed_enable,
  output reg o_battery_switch_off,
  output reg o_warm_voltage_reduce,
  output reg o_fault_int
);

  localparam [31:0] TICK_LAST = TICK_CYCLES - 32'h1;
  localparam [7:0] WDT_40 = `CTC_WDT_40S;
  localparam [7:0] WDT_80 = `CTC_WDT_80S;
  localparam [7:0] WDT_160 = `CTC_WDT_160S;
  localparam [4:0] HRS_5 = `CTC_SAFE_5H;
  localparam [4:0] HRS_8 = `CTC_SAFE_8H;
  localparam [4:0] HRS_12 = `CTC_SAFE_12H;
  localparam [4:0] HRS_20 = `CTC_SAFE_20H;
  localparam [16:0] SEC_HOUR = `CTC_SEC_PER_HOUR;
  localparam [16:0] SAFE_5 = HRS_5 * SEC_HOUR;
  localparam [16:0] SAFE_8 = HRS_8 * SEC_HOUR;
  localparam [16:0] SAFE_12 = HRS_12 * SEC_HOUR;
  localparam [16:0] SAFE_20 = HRS_20 * SEC_HOUR;
  localparam [6:0] IRR_STEP = `CTC_IRR_STEP_MOHM;
  localparam [6:0] IRV_STEP = `CTC_IRV_STEP_MV;
  localparam [6:0] TEMP_BASE = `CTC_TEMP_BASE_C;
  localparam [6:0] TEMP_STEP = `CTC_TEMP_STEP_C;
  localparam [6:0] COLD_LO = `CTC_COLD_PCT_LO;
  localparam [6:0] COLD_HI = `CTC_COLD_PCT_HI;

  // Watchdog period in seconds, zero means disabled
  function [7:0] wdt_period;
    input [1:0] code;
    begin
      case (code)
        2'h1: wdt_period = WDT_40;
        2'h2: wdt_period = WDT_80;
        2'h3: wdt_period = WDT_160;
        default: wdt_period = 8'h00;
      endcase
    end
  endfunction

  // Safety limit in seconds
  function [16:0] safe_limit;
    input [1:0] code;
    begin
      case (code)
        2'h0: safe_limit = SAFE_5;
        2'h1: safe_limit = SAFE_8;
        2'h2: safe_limit = SAFE_12;
        default: safe_limit = SAFE_20;
      endcase
    end
  endfunction

  reg [7:0] term_timer_q;
  reg [7:0] ir_therm_q;
  reg [7:0] misc_q;
  reg sda_out_q;
  reg [31:0] tick_cnt_q;
  reg tick_q;
  reg [7:0] wdt_sec_q;
  reg [16:0] safe_sec_q;
  reg half_phase_q;
  reg safe_done_q;
  reg battery_overvoltage_flag_q;
  reg [7:0] rd_data;

  wire [7:0] reg_ptr;
  wire wr_en;
  wire [7:0] wr_data;
  wire rd_take;
  wire host_access;

  ctc_serial_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_rd_data(rd_data),
    .o_sda_oe(o_sda_oe),
    .o_reg_ptr(reg_ptr),
    .o_wr_en(wr_en),
    .o_wr_data(wr_data),
    .o_rd_take(rd_take),
    .o_access(host_access)
  );

  // Open drain: data line only ever pulled low
  assign o_sda = sda_out_q;

  wire wr_term_timer = wr_en & (reg_ptr == `CTC_ADDR_TERM_TIMER);
  wire wr_ir_therm = wr_en & (reg_ptr == `CTC_ADDR_IR_THERM);
  wire wr_misc = wr_en & (reg_ptr == `CTC_ADDR_MISC);
  wire rd_fault = rd_take & (reg_ptr == `CTC_ADDR_FAULT);
  wire [1:0] wdt_code = term_timer_q[`CTC_B_WDT_HI:`CTC_B_WDT_LO];
  wire [7:0] wdt_lim = wdt_period(wdt_code);
  wire [16:0] safe_lim = safe_limit(term_timer_q[`CTC_B_TMR_HI:`CTC_B_TMR_LO]);
  wire safe_run = i_fast_charging & term_timer_q[`CTC_B_EN_TIMER];
  wire slow = misc_q[`CTC_B_HALFSPEED] & (i_input_limit_active | i_thermal_reg_active);
  wire safe_step = tick_q & safe_run & ~safe_done_q & (~slow | half_phase_q);
  wire safe_hit = safe_step & (safe_sec_q + 17'h1 >= safe_lim);
  wire wdt_restart = host_access | (wr_term_timer & (wr_data[`CTC_B_WDT_HI:`CTC_B_WDT_LO] != wdt_code));
  wire wdt_hit = tick_q & (wdt_lim != 8'h00) & ~wdt_restart & (wdt_sec_q + 8'h01 >= wdt_lim);

  // Read mux; unmapped addresses read zero
  always @* begin
    rd_data = 8'h00;
    case (reg_ptr)
      `CTC_ADDR_TERM_TIMER: rd_data = term_timer_q;
      `CTC_ADDR_IR_THERM: rd_data = ir_therm_q;
      `CTC_ADDR_MISC: rd_data = misc_q;
      `CTC_ADDR_FAULT: begin
        rd_data[`CTC_B_WDT_FAULT] = o_watchdog_fault;
        rd_data[`CTC_B_CHG_FAULT_HI:`CTC_B_CHG_FAULT_LO] = safe_done_q ? `CTC_CHG_FAULT_TIMER : 2'h0;
        rd_data[`CTC_B_BATTERY_OVERVOLTAGE_FLAG] = battery_overvoltage_flag_q;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // Register file
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      term_timer_q <= `CTC_RST_TERM_TIMER;
      ir_therm_q <= `CTC_RST_IR_THERM;
      misc_q <= `CTC_RST_MISC;
      sda_out_q <= 1'b0;
    end else begin
      if (wr_term_timer) begin
        term_timer_q <= wr_data;
      end
      if (wr_ir_therm) begin
        ir_therm_q <= wr_data;
      end
      // Reserved bits stored as written; host keeps them at 1 and 0
      if (wr_misc) begin
        misc_q <= wr_data;
      end else if (i_port_detect_done) begin
        // Host write wins over the self-clear
        misc_q[`CTC_B_FORCE_DET] <= 1'b0;
      end
    end
  end

  // One second tick; long count is a parameter so simulation can shrink it
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // Host watchdog
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wdt_sec_q <= 8'h00;
      o_watchdog_fault <= 1'b0;
    end else begin
      if (wdt_restart || wdt_lim == 8'h00 || wdt_hit) begin
        wdt_sec_q <= 8'h00;
      end else if (tick_q) begin
        wdt_sec_q <= wdt_sec_q + 8'h01;
      end
      // Set wins over clear-on-read
      if (wdt_hit) begin
        o_watchdog_fault <= 1'b1;
      end else if (rd_fault) begin
        o_watchdog_fault <= 1'b0;
      end
    end
  end

  // Charge safety timer, counts seconds while fast charging
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      safe_sec_q <= 17'h0;
      half_phase_q <= 1'b0;
      safe_done_q <= 1'b0;
      o_safety_timer_expired <= 1'b0;
    end else begin
      if (!safe_run) begin
        // Leaving fast charge restarts the budget
        safe_sec_q <= 17'h0;
        half_phase_q <= 1'b0;
        safe_done_q <= 1'b0;
      end else begin
        if (tick_q && slow) begin
          half_phase_q <= ~half_phase_q;
        end
        if (safe_step) begin
          safe_sec_q <= safe_sec_q + 17'h1;
        end
        if (safe_hit) begin
          safe_done_q <= 1'b1;
        end
      end
      o_safety_timer_expired <= safe_done_q;
    end
  end

  // Battery overvoltage flag, set wins over clear-on-read
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      battery_overvoltage_flag_q <= 1'b0;
    end else if (i_bat_ov_event) begin
      battery_overvoltage_flag_q <= 1'b1;
    end else if (rd_fault) begin
      battery_overvoltage_flag_q <= 1'b0;
    end
  end

  // Control outputs, all registered
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_term_enable <= 1'b1;
      o_done_status <= 1'b0;
      o_wdt_period_s <= WDT_40;
      o_safety_timer_enable <= 1'b1;
      o_fast_charge_time_limit_h <= HRS_8;
      o_cold_charge_current_pct <= COLD_LO;
      o_ir_comp_resistance_mohm <= 7'h00;
      o_ir_comp_voltage_limit_mv <= 7'h00;
      o_die_temp_threshold_c <= TEMP_BASE + TEMP_STEP * 7'h3;
      o_force_port_detect <= 1'b0;
      o_timer_halfspeed_enable <= 1'b1;
      o_battery_switch_off <= 1'b0;
      o_warm_voltage_reduce <= 1'b0;
      o_fault_int <= 1'b0;
    end else begin
      o_term_enable <= term_timer_q[`CTC_B_EN_TERM];
      // Early indication only applies while termination is enabled
      o_done_status <= term_timer_q[`CTC_B_EN_TERM] & (i_term_current_reached |
        (term_timer_q[`CTC_B_TERM_STAT] & i_fast_charging & i_current_below_800ma));
      o_wdt_period_s <= wdt_lim;
      o_safety_timer_enable <= term_timer_q[`CTC_B_EN_TIMER];
      case (term_timer_q[`CTC_B_TMR_HI:`CTC_B_TMR_LO])
        2'h0: o_fast_charge_time_limit_h <= HRS_5;
        2'h1: o_fast_charge_time_limit_h <= HRS_8;
        2'h2: o_fast_charge_time_limit_h <= HRS_12;
        default: o_fast_charge_time_limit_h <= HRS_20;
      endcase
      o_cold_charge_current_pct <= term_timer_q[`CTC_B_COLD_SCALE] ? COLD_HI : COLD_LO;
      o_ir_comp_resistance_mohm <= IRR_STEP * {4'h0, ir_therm_q[`CTC_B_IRR_HI:`CTC_B_IRR_LO]};
      o_ir_comp_voltage_limit_mv <= IRV_STEP * {4'h0, ir_therm_q[`CTC_B_IRV_HI:`CTC_B_IRV_LO]};
      o_die_temp_threshold_c <= TEMP_BASE + TEMP_STEP * {5'h00, ir_therm_q[`CTC_B_TEMP_HI:`CTC_B_TEMP_LO]};
      o_force_port_detect <= misc_q[`CTC_B_FORCE_DET];
      o_timer_halfspeed_enable <= misc_q[`CTC_B_HALFSPEED];
      o_battery_switch_off <= misc_q[`CTC_B_BATT_OFF];
      o_warm_voltage_reduce <= misc_q[`CTC_B_WARM_VRED];
      // Timer expiry is itself a charge fault
      o_fault_int <= (misc_q[`CTC_B_MASK_CHG] & (i_charge_fault_event | safe_hit)) |
        (misc_q[`CTC_B_MASK_BAT] & i_bat_ov_event);
    end
  end

endmodule // ctc_control_regs

// ===== dv/ctc_control_regs_props.sv
`timescale 1ns/1ps
module ctc_control_regs_props (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_charge_fault_event,
  input wire i_bat_ov_event,
  input wire [7:0] o_wdt_period_s,
  input wire o_watchdog_fault,
  input wire [4:0] o_fast_charge_time_limit_h,
  input wire o_safety_timer_expired,
  input wire [6:0] o_cold_charge_current_pct,
  input wire [6:0] o_ir_comp_resistance_mohm,
  input wire [6:0] o_ir_comp_voltage_limit_mv,
  input wire [6:0] o_die_temp_threshold_c,
  input wire o_fault_int
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wdt_period_a: assert property (o_wdt_period_s inside {8'h00, 8'h28, 8'h50, 8'hA0})
    else $error("watchdog period outside decode");
  time_limit_a: assert property (o_fast_charge_time_limit_h inside {5'h05, 5'h08, 5'h0C, 5'h14})
    else $error("time limit outside decode");
  cold_pct_a: assert property (o_cold_charge_current_pct inside {7'h32, 7'h14})
    else $error("cold scale outside decode");
  ir_res_a: assert property (o_ir_comp_resistance_mohm % 7'h0A == 7'h00 && o_ir_comp_resistance_mohm <= 7'h46)
    else $error("ir resistance off grid");
  ir_clamp_a: assert property (o_ir_comp_voltage_limit_mv[3:0] == 4'h0 && o_ir_comp_voltage_limit_mv <= 7'h70)
    else $error("ir clamp off grid");
  die_temp_a: assert property (o_die_temp_threshold_c inside {7'h3C, 7'h50, 7'h64, 7'h78})
    else $error("die threshold outside decode");
  wdt_fault_a: assert property ($rose(o_watchdog_fault) |-> o_wdt_period_s != 8'h00)
    else $error("watchdog fault while disabled");
  int_cause_a: assert property (o_fault_int |->
    (($past(i_charge_fault_event) || $past(i_bat_ov_event)) or (##1 o_safety_timer_expired)))
    else $error("interrupt without cause");
endmodule // ctc_control_regs_props

// ===== dv/ctc_host_model.sv
`timescale 1ns/1ps
`include "ctc_consts.vh"
module ctc_host_model #(
  parameter logic [6:0] DEV_ADDR = `CTC_DEV_ADDR
) (
  input wire i_ref_clk,
  input wire i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // Three clocks a level: slave needs two
  localparam int HALF = 3;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic bx(input logic b, output logic q);
    o_sda_low = ~b;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    q = i_sda;
    o_scl = 1'b0;
    wt(1);
  endtask
  task automatic by(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bx(d[i], q[i]);
    end
    bx(ai, ak);
  endtask
  task automatic sta();
    o_sda_low = 1'b0;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_low = 1'b1;
    wt(HALF);
    o_scl = 1'b0;
    wt(HALF);
  endtask
  task automatic sto();
    o_sda_low = 1'b1;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_low = 1'b0;
    wt(HALF);
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] p, input logic [7:0] d, output logic nk);
    logic [7:0] q;
    logic a0, a1, a2;
    sta();
    by({dv, 1'b0}, 1'b1, q, a0);
    by(p, 1'b1, q, a1);
    by(d, 1'b1, q, a2);
    sto();
    nk = a0 | a1 | a2;
  endtask
  // Single byte read, closed by a NACK
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    logic a;
    sta();
    by({DEV_ADDR, 1'b0}, 1'b1, q, a);
    by(p, 1'b1, q, a);
    sta();
    by({DEV_ADDR, 1'b1}, 1'b1, q, a);
    by(8'hFF, 1'b1, d, a);
    sto();
  endtask
endmodule // ctc_host_model

// ===== dv/ctc_control_regs_tb.sv
`timescale 1ns/1ps
`include "ctc_consts.vh"
`define TB_CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %0h got %0h", n, (e), (g)); end end
module ctc_control_regs_tb;
  // Short tick keeps the watchdog within a few hundred clocks
  localparam int TK = 8;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic fc = 1'b0, th = 1'b0, b8 = 1'b0, ce = 1'b0, be = 1'b0, fb = 1'b0, il = 1'b0, tr = 1'b0;
  logic scl, sdl;
  wire sda_w, o_sda, o_oe, o_term, o_done, o_wf, o_ten, o_exp, o_fint;
  wire o_fpd, o_hs, o_bo, o_wv;
  wire [7:0] o_wdt;
  wire [4:0] o_lim;
  wire [6:0] o_cold, o_irr, o_irv, o_tmp;
  wire [3:0] misc_w = {o_fpd, o_hs, o_bo, o_wv};
  logic [7:0] mdl [0:15];
  logic [31:0] xs_q = 32'h0000_0044;
  int n_fail = 0;
  int comparisons = 0;
  logic [7:0] wdt_t [4] = '{8'h00, 8'h28, 8'h50, 8'hA0};
  logic [4:0] lim_t [4] = '{5'h05, 5'h08, 5'h0C, 5'h14};
  assign sda_w = ~(sdl | (o_oe & ~o_sda));
  always #2.5 i_ref_clk = ~i_ref_clk;
  ctc_host_model host_u (.i_ref_clk(i_ref_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sdl));
  ctc_control_regs #(.TICK_CYCLES(32'h0000_0008)) dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe(o_oe), .i_fast_charging(fc),
    .i_term_current_reached(th), .i_current_below_800ma(b8), .i_input_limit_active(il),
    .i_thermal_reg_active(tr), .i_port_detect_done(1'b0), .i_charge_fault_event(ce),
    .i_bat_ov_event(be), .o_term_enable(o_term), .o_done_status(o_done), .o_wdt_period_s(o_wdt),
    .o_watchdog_fault(o_wf), .o_safety_timer_enable(o_ten), .o_fast_charge_time_limit_h(o_lim),
    .o_safety_timer_expired(o_exp), .o_cold_charge_current_pct(o_cold), .o_ir_comp_resistance_mohm(o_irr),
    .o_ir_comp_voltage_limit_mv(o_irv), .o_die_temp_threshold_c(o_tmp), .o_force_port_detect(o_fpd),
    .o_timer_halfspeed_enable(o_hs), .o_battery_switch_off(o_bo), .o_warm_voltage_reduce(o_wv),
    .o_fault_int(o_fint));
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_outs();
    logic [7:0] r5, r6;
    r5 = mdl[5];
    r6 = mdl[6];
    `TB_CHK("term_en", r5[7], o_term)
    `TB_CHK("wdt_s", wdt_t[r5[5:4]], o_wdt)
    `TB_CHK("tmr_en", r5[3], o_ten)
    `TB_CHK("tmr_h", lim_t[r5[2:1]], o_lim)
    `TB_CHK("cold", r5[0] ? 7'h14 : 7'h32, o_cold)
    `TB_CHK("ir_r", 7'h0A * r6[7:5], o_irr)
    `TB_CHK("ir_v", 7'h10 * r6[4:2], o_irv)
    `TB_CHK("temp", 7'h3C + 7'h14 * r6[1:0], o_tmp)
    `TB_CHK("misc", mdl[7][7:4], misc_w)
  endtask
  task automatic wr_chk(input logic [7:0] p, input logic [7:0] d);
    logic nk;
    logic [7:0] q;
    host_u.wr(`CTC_DEV_ADDR, p, d, nk);
    `TB_CHK("ack", 1'b0, nk)
    if (p >= 8'h05 && p <= 8'h07) begin
      mdl[p[3:0]] = d;
    end
    chk_outs();
    host_u.rd(p, q);
    `TB_CHK("readback", mdl[p[3:0]], q)
  endtask
  function automatic logic [31:0] xs_next(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  initial begin
    logic [31:0] r;
    logic [7:0] q;
    logic nk;
    for (int i = 0; i < 16; i++) begin
      mdl[i] = 8'h00;
    end
    mdl[5] = 8'h9A;
    mdl[6] = 8'h03;
    mdl[7] = 8'h4B;
    tick(12);
    i_rst = 1'b0;
    tick(2);
    chk_outs();
    for (int i = 5; i <= 7; i++) begin
      host_u.rd(i[7:0], q);
      `TB_CHK("reset", mdl[i], q)
    end
    for (int i = 0; i < 8; i++) begin
      xs_q = xs_next(xs_q);
      r = xs_q;
      wr_chk(8'h05, {r[7:6], i[1:0], r[3], i[1:0], r[0]});
      wr_chk(8'h06, {i[2:0], r[12:10], i[1:0]});
      wr_chk(8'h07, {r[23:20], 2'b10, r[17:16]});
      fc = r[24];
      th = r[25];
      b8 = r[26];
      il = r[29];
      tr = r[30];
      tick(3);
      `TB_CHK("done", mdl[5][7] & (th | (mdl[5][6] & fc & b8)), o_done)
      ce = r[27];
      be = r[28];
      tick(1);
      ce = 1'b0;
      be = 1'b0;
      `TB_CHK("int", (mdl[7][1] & r[27]) | (mdl[7][0] & r[28]), o_fint)
      fb = fb | r[28];
    end
    // Unmapped place, then a foreign device address
    wr_chk(8'h00, 8'h5A);
    host_u.wr(`CTC_DEV_ADDR ^ 7'h01, 8'h05, 8'h00, nk);
    `TB_CHK("nack", 1'b1, nk)
    chk_outs();
    wr_chk(8'h05, {mdl[5][7:6], 2'b01, mdl[5][3:0]});
    tick(25 * TK);
    `TB_CHK("wdt_early", 1'b0, o_wf)
    tick(8 * TK);
    `TB_CHK("wdt_fault", 1'b1, o_wf)
    host_u.wr(`CTC_DEV_ADDR, 8'h09, 8'h00, nk);
    host_u.rd(8'h09, q);
    `TB_CHK("fault_reg", 8'h80 | (fb ? 8'h08 : 8'h00), q)
    host_u.rd(8'h09, q);
    `TB_CHK("fault_clr", 8'h00, q)
    wr_chk(8'h05, {mdl[5][7:6], 2'b00, mdl[5][3:0]});
    tick(50 * TK);
    `TB_CHK("wdt_off", 1'b0, o_wf)
    // Shortest budget is far beyond this run
    `TB_CHK("tmr_exp", 1'b0, o_exp)
    test_done();
  end
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    n_fail++;
    test_done();
  end
endmodule // ctc_control_regs_tb
bind ctc_control_regs ctc_control_regs_props props_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_charge_fault_event(i_charge_fault_event), .i_bat_ov_event(i_bat_ov_event),
  .o_wdt_period_s(o_wdt_period_s), .o_watchdog_fault(o_watchdog_fault),
  .o_fast_charge_time_limit_h(o_fast_charge_time_limit_h), .o_safety_timer_expired(o_safety_timer_expired),
  .o_cold_charge_current_pct(o_cold_charge_current_pct), .o_ir_comp_resistance_mohm(o_ir_comp_resistance_mohm),
  .o_ir_comp_voltage_limit_mv(o_ir_comp_voltage_limit_mv), .o_die_temp_threshold_c(o_die_temp_threshold_c),
  .o_fault_int(o_fault_int));
